// [core/xapu_top.sv]
// Summary of operation
// - base register places memory in 2KB granules
// - compat mode: 16-bit pointer addressing, indirect still uses top byte
// - wide mode: 20-bit program, 16-bit stack range
// - data address space stays 16 bits
// - relocate bit moves vectors to 0x3000
// - indirect high byte: port2 or own register
// - stack flag read-only, shows extended stack
// - mode bits 00 compat, 1x wide
// - indirect top byte only for indirect accesses
// - pointer access uses selected pointer bytes
// - step direction bits pick decrement per pointer
// - auto toggle flips selection on pointer use
// - select bit writes and reads live selection
// - first top byte carries in wide mode
// - second top byte carries in wide mode
// - small on-chip memory ignores top bytes
// - mode and base registers need unlock
//
// Added by the designer: the Avalon-MM slave port.
`include "xapu_map.svh"
`default_nettype none
module xapu_top #(
  parameter int ONCHIP_AW = 16,
  parameter int TA_WIN_CYC = `XAPU_TA_WIN
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // cpu core
  input wire xapu_pkg::xapu_core_req_t core_req,
  output xapu_pkg::xapu_core_rsp_t core_rsp
);

  initial begin
    if (ONCHIP_AW < 8 || ONCHIP_AW > 24) $error("ONCHIP_AW out of range");
    if (TA_WIN_CYC < 3 || TA_WIN_CYC > 15) $error("TA_WIN_CYC out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [23:0] step24(input logic [23:0] v, input logic dec, input logic wide);
    logic [23:0] r;
    r = dec ? v - 24'h000001 : v + 24'h000001;
    if (!wide) begin
      r[23:16] = v[23:16];
    end
    return r;
  endfunction

  function automatic logic [23:0] mask_aw(input logic [23:0] a);
    logic [23:0] m;
    m = 24'hFFFFFF >> (24 - ONCHIP_AW);
    return a & m;
  endfunction

  xapu_pkg::xapu_state_t st_r, st_nxt;

  logic acc, bus_wr, bus_rd, wide, sel;
  logic [7:0] wd, rd;
  logic [23:0] raw, ptr, ptr_s;

  assign acc = avs_read | avs_write;
  assign avs_waitrequest = acc & ~st_r.ack;
  assign bus_wr = avs_write & st_r.ack & avs_byteenable[0];
  assign bus_rd = avs_read & st_r.ack;
  assign wd = avs_writedata[7:0];
  assign wide = st_r.addr_mode_ctrl[`XAPU_ADDR_MODE_CTRL_AM1];
  assign sel = st_r.pointer_select_control[`XAPU_DPS_SEL];
  assign ptr = sel ? {st_r.p1t, st_r.p1h, st_r.p1l} : {st_r.p0t, st_r.p0h, st_r.p0l};

  ////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    case (avs_address)
      `XAPU_OFF_P0L: rd = st_r.p0l;
      `XAPU_OFF_P0H: rd = st_r.p0h;
      `XAPU_OFF_P1L: rd = st_r.p1l;
      `XAPU_OFF_P1H: rd = st_r.p1h;
      `XAPU_OFF_DPS: rd = st_r.pointer_select_control;
      `XAPU_OFF_P0T: rd = st_r.p0t;
      `XAPU_OFF_P1T: rd = st_r.p1t;
      `XAPU_OFF_ADDR_MODE_CTRL: rd = (st_r.addr_mode_ctrl & `XAPU_ADDR_MODE_CTRL_WMASK) | ({7'h00, wide} << `XAPU_ADDR_MODE_CTRL_SA);
      `XAPU_OFF_BASE: rd = st_r.base;
      `XAPU_OFF_TAKEY: rd = {7'h00, st_r.win != 4'h0};
      `XAPU_OFF_RIH: rd = st_r.rih;
      `XAPU_OFF_RIT: rd = st_r.rit;
      default: rd = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt = st_r;
    raw = 24'h000000;
    ptr_s = step24(ptr, sel ? st_r.pointer_select_control[`XAPU_DPS_ID1] : st_r.pointer_select_control[`XAPU_DPS_ID0], wide);
    st_nxt.ack = acc & ~st_r.ack;
    // load in the wait cycle so read data stands at the accept edge
    if (avs_read && !st_r.ack) begin
      st_nxt.rdata = rd;
    end
    if (st_r.win != 4'h0) begin
      st_nxt.win = st_r.win - 4'h1;
    end
    // core side: pointer step and toggle
    if (core_req.ptr_inc) begin
      if (sel) begin
        {st_nxt.p1t, st_nxt.p1h, st_nxt.p1l} = ptr_s;
      end else begin
        {st_nxt.p0t, st_nxt.p0h, st_nxt.p0l} = ptr_s;
      end
    end
    if (core_req.ptr_use && st_r.pointer_select_control[`XAPU_DPS_TSL]) begin
      st_nxt.pointer_select_control[`XAPU_DPS_SEL] = ~sel;
    end
    // external address forming
    if (core_req.movx_ri) begin
      raw = {st_r.rit, st_r.addr_mode_ctrl[`XAPU_ADDR_MODE_CTRL_HISRC] ? st_r.rih : core_req.port2_latch, core_req.ri_low};
    end else begin
      raw = {wide ? ptr[23:16] : 8'h00, ptr[15:0]};
    end
    if (core_req.movx_ri || core_req.movx_ptr) begin
      st_nxt.xaddr = raw + {5'h00, st_r.base, 11'h000};
    end
    st_nxt.stk = wide ? {core_req.stack_high_byte, core_req.stack_low_byte}
                      : {8'h00, core_req.stack_low_byte};
    // bus writes win over core updates
    if (bus_wr) begin
      case (avs_address)
        `XAPU_OFF_P0L: st_nxt.p0l = wd;
        `XAPU_OFF_P0H: st_nxt.p0h = wd;
        `XAPU_OFF_P1L: st_nxt.p1l = wd;
        `XAPU_OFF_P1H: st_nxt.p1h = wd;
        `XAPU_OFF_DPS: st_nxt.pointer_select_control = wd & `XAPU_DPS_WMASK;
        `XAPU_OFF_P0T: st_nxt.p0t = wd;
        `XAPU_OFF_P1T: st_nxt.p1t = wd;
        `XAPU_OFF_RIH: st_nxt.rih = wd;
        `XAPU_OFF_RIT: st_nxt.rit = wd;
        `XAPU_OFF_ADDR_MODE_CTRL: begin
          if (st_r.win != 4'h0) begin
            st_nxt.addr_mode_ctrl = wd & `XAPU_ADDR_MODE_CTRL_WMASK;
            st_nxt.win = 4'h0;
          end
        end
        `XAPU_OFF_BASE: begin
          if (st_r.win != 4'h0) begin
            st_nxt.base = wd;
            st_nxt.win = 4'h0;
          end
        end
        `XAPU_OFF_TAKEY: begin
          case (st_r.ta)
            xapu_pkg::TA_IDLE: begin
              st_nxt.ta = (wd == `XAPU_TA_KEY1) ? xapu_pkg::TA_KEYED : xapu_pkg::TA_IDLE;
            end
            xapu_pkg::TA_KEYED: begin
              st_nxt.ta = xapu_pkg::TA_IDLE;
              if (wd == `XAPU_TA_KEY2) begin
                st_nxt.win = 4'(TA_WIN_CYC);
              end
            end
            default: st_nxt.ta = xapu_pkg::TA_IDLE;
          endcase
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.p0l <= `XAPU_RST_VAL;
      st_r.p0h <= `XAPU_RST_VAL;
      st_r.p1l <= `XAPU_RST_VAL;
      st_r.p1h <= `XAPU_RST_VAL;
      st_r.pointer_select_control <= `XAPU_RST_VAL;
      st_r.p0t <= `XAPU_RST_VAL;
      st_r.p1t <= `XAPU_RST_VAL;
      st_r.addr_mode_ctrl <= `XAPU_RST_VAL;
      st_r.base <= `XAPU_RST_VAL;
      st_r.rih <= `XAPU_RST_VAL;
      st_r.rit <= `XAPU_RST_VAL;
      st_r.ta <= xapu_pkg::TA_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign avs_readdata = {24'h000000, st_r.rdata};
  assign core_rsp.xram_addr = st_r.xaddr;
  assign core_rsp.dmem_addr = mask_aw(st_r.xaddr);
  assign core_rsp.data_addr = st_r.xaddr[15:0];
  assign core_rsp.stack_addr = st_r.stk;
  assign core_rsp.vector_base = st_r.addr_mode_ctrl[`XAPU_ADDR_MODE_CTRL_IVEC] ? `XAPU_VEC_RELOC : `XAPU_VEC_NORM;
  assign core_rsp.prog_wide = wide;
  assign core_rsp.ext_stack_flag = wide;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  logic no_ptr_wr;
  assign no_ptr_wr = ~bus_wr;

  sequence s_key1;
    bus_wr && avs_address == `XAPU_OFF_TAKEY && wd == `XAPU_TA_KEY1 && st_r.ta == xapu_pkg::TA_IDLE;
  endsequence
  sequence s_key2;
    bus_wr && avs_address == `XAPU_OFF_TAKEY && wd == `XAPU_TA_KEY2;
  endsequence
  sequence s_keyed_wr;
    bus_wr && avs_address == `XAPU_OFF_TAKEY && st_r.ta == xapu_pkg::TA_KEYED;
  endsequence
  sequence s_dps_wr;
    bus_wr && avs_address == `XAPU_OFF_DPS;
  endsequence
  sequence s_wide_run;
    wide ##1 wide;
  endsequence

  property p_unlock;
    @(posedge clk) disable iff (sys_rst)
    s_key1 ##1 (!bus_wr)[*1] ##[0:20] s_key2 |=> st_r.win == 4'(TA_WIN_CYC);
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock did not open window");

  property p_protect;
    @(posedge clk) disable iff (sys_rst)
    bus_wr && avs_address == `XAPU_OFF_BASE && st_r.win == 4'h0 |=> $stable(st_r.base);
  endproperty
  a_protect: assert property (p_protect) else $error("protected write not ignored");

  property p_ri_src;
    @(posedge clk) disable iff (sys_rst)
    core_req.movx_ri && st_r.base == 8'h00 |=>
      st_r.xaddr[15:8] == ($past(st_r.addr_mode_ctrl[`XAPU_ADDR_MODE_CTRL_HISRC]) ? $past(st_r.rih) : $past(core_req.port2_latch));
  endproperty
  a_ri_src: assert property (p_ri_src) else $error("indirect high byte wrong");

  property p_ri_top;
    @(posedge clk) disable iff (sys_rst)
    core_req.movx_ri && st_r.base == 8'h00 |=> st_r.xaddr[23:16] == $past(st_r.rit);
  endproperty
  a_ri_top: assert property (p_ri_top) else $error("indirect top byte wrong");

  property p_ptr_top;
    @(posedge clk) disable iff (sys_rst)
    core_req.movx_ptr && !core_req.movx_ri && wide && st_r.base == 8'h00 |=>
      st_r.xaddr == $past(ptr);
  endproperty
  a_ptr_top: assert property (p_ptr_top) else $error("pointer address wrong");

  property p_compat;
    @(posedge clk) disable iff (sys_rst)
    core_req.movx_ptr && !core_req.movx_ri && !wide && st_r.base == 8'h00 |=> st_r.xaddr[23:16] == 8'h00;
  endproperty
  a_compat: assert property (p_compat) else $error("compat mode used top byte");

  property p_toggle;
    @(posedge clk) disable iff (sys_rst)
    core_req.ptr_use && st_r.pointer_select_control[`XAPU_DPS_TSL] && no_ptr_wr |=> sel != $past(sel);
  endproperty
  a_toggle: assert property (p_toggle) else $error("selection did not toggle");

  property p_dec0;
    @(posedge clk) disable iff (sys_rst)
    core_req.ptr_inc && !sel && st_r.pointer_select_control[`XAPU_DPS_ID0] && wide && no_ptr_wr |=>
      {st_r.p0t, st_r.p0h, st_r.p0l} == $past({st_r.p0t, st_r.p0h, st_r.p0l}) - 24'h000001;
  endproperty
  a_dec0: assert property (p_dec0) else $error("first pointer decrement wrong");

  property p_inc1;
    @(posedge clk) disable iff (sys_rst)
    core_req.ptr_inc && sel && !st_r.pointer_select_control[`XAPU_DPS_ID1] && wide && no_ptr_wr |=>
      {st_r.p1t, st_r.p1h, st_r.p1l} == $past({st_r.p1t, st_r.p1h, st_r.p1l}) + 24'h000001;
  endproperty
  a_inc1: assert property (p_inc1) else $error("second pointer increment wrong");

  property p_compat_step;
    @(posedge clk) disable iff (sys_rst)
    core_req.ptr_inc && !sel && !wide && no_ptr_wr |=>
      $stable(st_r.p0t);
  endproperty
  a_compat_step: assert property (p_compat_step) else $error("compat step touched top byte");

  property p_rd_dps;
    @(posedge clk) disable iff (sys_rst)
    bus_rd && avs_address == `XAPU_OFF_DPS && $stable(st_r.pointer_select_control) |->
      avs_readdata[7:0] == st_r.pointer_select_control;
  endproperty
  a_rd_dps: assert property (p_rd_dps) else $error("select read not live");

  property p_sel_write;
    @(posedge clk) disable iff (sys_rst)
    s_dps_wr |=>
      st_r.pointer_select_control == ($past(wd) & `XAPU_DPS_WMASK);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select write not stored");

  property p_sa_read;
    @(posedge clk) disable iff (sys_rst)
    bus_rd && avs_address == `XAPU_OFF_ADDR_MODE_CTRL |->
      avs_readdata[`XAPU_ADDR_MODE_CTRL_SA] == wide;
  endproperty
  a_sa_read: assert property (p_sa_read) else $error("stack flag read wrong");

  property p_addr_mode_ctrl_prot;
    @(posedge clk) disable iff (sys_rst)
    bus_wr && avs_address == `XAPU_OFF_ADDR_MODE_CTRL && st_r.win == 4'h0 |=>
      $stable(st_r.addr_mode_ctrl);
  endproperty
  a_addr_mode_ctrl_prot: assert property (p_addr_mode_ctrl_prot) else $error("mode write not ignored");

  property p_win_count;
    @(posedge clk) disable iff (sys_rst)
    st_r.win != 4'h0 && !bus_wr |=>
      st_r.win == $past(st_r.win) - 4'h1;
  endproperty
  a_win_count: assert property (p_win_count) else $error("window did not count down");

  property p_key_reset;
    @(posedge clk) disable iff (sys_rst)
    s_keyed_wr |=>
      st_r.ta == xapu_pkg::TA_IDLE;
  endproperty
  a_key_reset: assert property (p_key_reset) else $error("key sequence not restarted");

  property p_vec_norm;
    @(posedge clk) disable iff (sys_rst)
    !st_r.addr_mode_ctrl[`XAPU_ADDR_MODE_CTRL_IVEC] |->
      core_rsp.vector_base == `XAPU_VEC_NORM;
  endproperty
  a_vec_norm: assert property (p_vec_norm) else $error("vector base not normal");

  property p_low_byte;
    @(posedge clk) disable iff (sys_rst)
    core_req.movx_ri |=>
      st_r.xaddr[7:0] == $past(core_req.ri_low);
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("granule moved low byte");

  property p_wide_stack;
    @(posedge clk) disable iff (sys_rst)
    s_wide_run |->
      core_rsp.stack_addr == {$past(core_req.stack_high_byte), $past(core_req.stack_low_byte)} &&
      core_rsp.ext_stack_flag;
  endproperty
  a_wide_stack: assert property (p_wide_stack) else $error("extended stack address wrong");

  property p_vec;
    @(posedge clk) disable iff (sys_rst)
    $rose(st_r.addr_mode_ctrl[`XAPU_ADDR_MODE_CTRL_IVEC]) |-> core_rsp.vector_base == `XAPU_VEC_RELOC;
  endproperty
  a_vec: assert property (p_vec) else $error("vector base not relocated");

  property p_stack;
    @(posedge clk) disable iff (sys_rst)
    !wide ##1 !wide |-> core_rsp.stack_addr[15:8] == 8'h00 && !core_rsp.ext_stack_flag;
  endproperty
  a_stack: assert property (p_stack) else $error("stack left internal range");

endmodule // xapu_top
`default_nettype wire

// [core/xapu_map.svh]
`ifndef XAPU_MAP_SVH
`define XAPU_MAP_SVH
// register indices (byte address is four times the index)
`define XAPU_OFF_P0L 8'h82
`define XAPU_OFF_P0H 8'h83
`define XAPU_OFF_P1L 8'h84
`define XAPU_OFF_P1H 8'h85
`define XAPU_OFF_DPS 8'h86
`define XAPU_OFF_P0T 8'h93
`define XAPU_OFF_P1T 8'h95
`define XAPU_OFF_ADDR_MODE_CTRL 8'h9D
`define XAPU_OFF_BASE 8'hC6
`define XAPU_OFF_TAKEY 8'hC7
`define XAPU_OFF_RIH 8'hDA
`define XAPU_OFF_RIT 8'hEA
// reset value of every register
`define XAPU_RST_VAL 8'h00
// mode control bits
`define XAPU_ADDR_MODE_CTRL_IVEC 5
`define XAPU_ADDR_MODE_CTRL_HISRC 3
`define XAPU_ADDR_MODE_CTRL_SA 2
`define XAPU_ADDR_MODE_CTRL_AM1 1
`define XAPU_ADDR_MODE_CTRL_WMASK 8'h2B
// pointer select bits
`define XAPU_DPS_ID1 7
`define XAPU_DPS_ID0 6
`define XAPU_DPS_TSL 5
`define XAPU_DPS_SEL 0
`define XAPU_DPS_WMASK 8'hE1
// unlock keys and window
`define XAPU_TA_KEY1 8'hAA
`define XAPU_TA_KEY2 8'h55
`define XAPU_TA_WIN 8
// address forming
`define XAPU_VEC_RELOC 20'h03000
`define XAPU_VEC_NORM 20'h00000
`define XAPU_BASE_SHIFT 11
`endif

// [core/xapu_pkg.sv]
`default_nettype none
package xapu_pkg;
  typedef enum logic [1:0] {
    TA_IDLE  = 2'b01,
    TA_KEYED = 2'b10
  } xapu_ta_t;
  typedef struct packed {
    logic movx_ri;
    logic movx_ptr;
    logic ptr_inc;
    logic ptr_use;
    logic [7:0] ri_low;
    logic [7:0] port2_latch;
    logic [7:0] stack_low_byte;
    logic [7:0] stack_high_byte;
  } xapu_core_req_t;
  typedef struct packed {
    logic [23:0] xram_addr;
    logic [23:0] dmem_addr;
    logic [15:0] data_addr;
    logic [15:0] stack_addr;
    logic [19:0] vector_base;
    logic prog_wide;
    logic ext_stack_flag;
  } xapu_core_rsp_t;
  typedef struct packed {
    logic [7:0] p0l, p0h, p1l, p1h, pointer_select_control, p0t, p1t, addr_mode_ctrl, base, rih, rit;
    xapu_ta_t ta;
    logic [3:0] win;
    logic ack;
    logic [7:0] rdata;
    logic [23:0] xaddr;
    logic [15:0] stk;
  } xapu_state_t;
endpackage
`default_nettype wire

// [test/xapu_cpu_model.sv]
`default_nettype none
module xapu_cpu_model (
  // core side
  input wire logic clk,
  output xapu_pkg::xapu_core_req_t core_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pl = 4'h0;
  logic [31:0] lv = 32'h00000000;
  assign core_req = {pl, lv};
  ////////////////////////////////
  // one-cycle instruction pulse, result settled on return
  task automatic pulse(input logic [3:0] k);
    @(posedge clk);
    pl <= k;
    @(posedge clk);
    pl <= 4'h0;
    @(posedge clk);
  endtask
  // low byte, port latch, stack low, stack high
  task automatic set(input logic [31:0] v);
    @(posedge clk);
    lv <= v;
  endtask
endmodule // xapu_cpu_model
`default_nettype wire

// [test/tb.sv]
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [7:0] a = 8'h00;
  logic rd_r = 1'h0;
  logic wr_r = 1'h0;
  logic [31:0] wd = 32'h00000000;
  logic [31:0] rdat;
  logic wq;
  xapu_pkg::xapu_core_req_t req;
  xapu_pkg::xapu_core_rsp_t rsp;
  int fails = 0;
  int cmp_count = 0;
  logic [7:0] rv [12] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h93, 8'h95, 8'h9D, 8'hC6, 8'hDA, 8'hEA, 8'h10};
  always #5 clk = ~clk;
  xapu_top i_xapu_top (.clk(clk), .sys_rst(sys_rst), .avs_address(a), .avs_read(rd_r),
    .avs_write(wr_r), .avs_byteenable(4'hF), .avs_writedata(wd), .avs_readdata(rdat),
    .avs_waitrequest(wq), .core_req(req), .core_rsp(rsp));
  xapu_cpu_model i_xapu_cpu_model (.clk(clk), .core_req(req));
  ////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chka(input logic [23:0] g, input logic [23:0] e);
    chk({8'h00, g}, {8'h00, e});
  endtask
  task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge clk);
    a <= ad;
    wd <= {24'h000000, d};
    if (w) wr_r <= 1'h1;
    else rd_r <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'h0 && n < 50);
    if (n >= 50) fails++;
    q = rdat;
    wr_r <= 1'h0;
    rd_r <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    logic [31:0] q;
    acc(1'h1, ad, d, q);
  endtask
  // read data is taken at the accept edge
  task automatic rc(input logic [7:0] ad, input logic [7:0] e);
    logic [31:0] q;
    acc(1'h0, ad, 8'h00, q);
    chk(q, {24'h000000, e});
  endtask
  task automatic op(input logic [3:0] k);
    i_xapu_cpu_model.pulse(k);
  endtask
  task automatic unlock;
    wr(8'hC7, 8'hAA);
    wr(8'hC7, 8'h55);
  endtask
  ////////////////////////////////
  task automatic t_reset;
    foreach (rv[i]) rc(rv[i], 8'h00);
    wr(8'h9D, 8'h02);
    rc(8'h9D, 8'h00);
    $display("end of reset test");
  endtask
  task automatic t_compat;
    chka({6'h00, rsp.prog_wide, rsp.ext_stack_flag, rsp.stack_addr}, 24'h000044);
    chka({4'h0, rsp.vector_base}, 24'h000000);
    wr(8'h93, 8'h01);
    wr(8'h82, 8'hFF);
    wr(8'h83, 8'hFF);
    op(4'h5);
    chka(rsp.xram_addr, 24'h00FFFF);
    op(4'h3);
    op(4'h5);
    chka(rsp.xram_addr, 24'h000000);
    rc(8'h93, 8'h01);
    wr(8'hEA, 8'h07);
    op(4'h8);
    chka(rsp.xram_addr, 24'h071234);
    $display("end of compat test");
  endtask
  task automatic t_wide;
    unlock();
    wr(8'h9D, 8'hFF);
    rc(8'h9D, 8'h2F);
    chka({6'h00, rsp.prog_wide, rsp.ext_stack_flag, rsp.stack_addr}, 24'h039A44);
    chka({4'h0, rsp.vector_base}, 24'h003000);
    wr(8'hDA, 8'hAB);
    op(4'h8);
    chka(rsp.xram_addr, 24'h07AB34);
    wr(8'h82, 8'hFF);
    wr(8'h83, 8'hFF);
    op(4'h5);
    chka(rsp.xram_addr, 24'h01FFFF);
    chka(rsp.dmem_addr, 24'h00FFFF);
    chka({8'h00, rsp.data_addr}, 24'h00FFFF);
    op(4'h3);
    op(4'h5);
    chka(rsp.xram_addr, 24'h020000);
    $display("end of wide test");
  endtask
  task automatic t_dual;
    wr(8'h95, 8'h05);
    wr(8'h85, 8'h12);
    wr(8'h84, 8'hFF);
    wr(8'h86, 8'h41);
    op(4'h3);
    op(4'h5);
    chka(rsp.xram_addr, 24'h051300);
    rc(8'h86, 8'h41);
    wr(8'h86, 8'h60);
    op(4'h3);
    rc(8'h86, 8'h61);
    op(4'h5);
    chka(rsp.xram_addr, 24'h051300);
    wr(8'h86, 8'h40);
    op(4'h5);
    chka(rsp.xram_addr, 24'h01FFFF);
    $display("end of dual pointer test");
  endtask
  task automatic t_base;
    unlock();
    wr(8'hC6, 8'h01);
    rc(8'hC6, 8'h01);
    wr(8'hC6, 8'h02);
    rc(8'hC6, 8'h01);
    op(4'h8);
    chka(rsp.xram_addr, 24'h07B334);
    $display("end of base test");
  endtask
  ////////////////////////////////
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'h0;
    i_xapu_cpu_model.set(32'h3412449A);
    t_reset();
    t_compat();
    t_wide();
    t_dual();
    t_base();
    print_verdict();
  end
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
endmodule // tb
`default_nettype wire
